/* File: hw/msl_pkg.sv */
// shared types and constants for the module status indicator driver
package msl_pkg;

	localparam int FLASH_HZ      = 2;
	localparam int CLK_HZ        = 125_000_000;
	localparam int FLASH_HALF_CYC = CLK_HZ / (2 * FLASH_HZ);
	localparam int IO_W          = 16;
	localparam int DIFF_W        = 8;
	localparam int NUM_BLK       = 6;

	typedef enum logic [1:0] {
		MSL_BLK_DC,
		MSL_BLK_DIFF,
		MSL_BLK_ANALOG
	} msl_blk_kind_t;

	typedef enum logic [1:0] {
		MSL_CYC_NONE,
		MSL_CYC_RUN,
		MSL_CYC_STOP
	} msl_cyc_t;

	typedef struct packed {
		logic normal_op;
		logic unit_test_busy;
		logic fw_update_busy;
		logic addr_init_busy;
		logic major_err;
		logic moderate_err;
		logic minor_err;
		logic ctrl_exec;
		logic cfg_done_ok;
		logic cfg_download;
		logic link_up_p1;
		logic link_up_p2;
		logic standalone;
		logic own_disconnected;
		logic ring_topology;
		logic higher_class;
		msl_cyc_t cyclic;
	} msl_status_t;

	typedef struct packed {
		logic [IO_W-1:0] in_pos;
		logic [IO_W-1:0] remote_output_bit;
		logic [IO_W-1:0] user_out;
		logic [IO_W-1:0] output_source_select;
		logic            bidir_in_pos;
		logic            bidir_remote_out;
		logic            bidir_user_out;
		logic            bidir_output_source_select;
		logic            bidir_output_value_direction;
		msl_blk_kind_t   kind;
	} msl_blk_t;

	typedef struct packed {
		logic run;
		logic err;
		logic ctrl_exec;
		logic config_state_indicator;
		logic link_p1;
		logic link_p2;
		logic cyclic_link_indicator;
		logic jack_p1;
		logic jack_p2;
	} msl_leds_t;

endpackage

/* File: hw/msl_driver.sv */
// front-panel status and terminal block indicator driver
`timescale 1ns/1ns

module msl_driver #(
	parameter int HALF_CYC = msl_pkg::FLASH_HALF_CYC,
	parameter int NBLK     = msl_pkg::NUM_BLK
) (
	input  wire logic                     mclk,
	input  wire logic                     rst_n,
	input  wire msl_pkg::msl_status_t     status_in,
	input  wire logic [$clog2(NBLK)-1:0]  blk_sel,
	input  wire msl_pkg::msl_blk_t [NBLK-1:0] blk_in,
	output msl_pkg::msl_leds_t            leds,
	output logic [NBLK-1:0]               terminal_no,
	output logic [msl_pkg::IO_W-1:0]      in_leds,
	output logic [msl_pkg::IO_W-1:0]      out_leds,
	output logic                          bidir_in_led,
	output logic                          bidir_out_led,
	output logic                          topology_fault
);
	import msl_pkg::*;

	// the one-hot terminal row and the divider cannot serve other sizes
	if (HALF_CYC < 1 || NBLK < 2 || NBLK > 8) begin : g_bad_param
		$error("msl_driver: unsupported parameters");
	end

	////////////////////////////////////////////////////////////////////
	// reset release and input synchronisers

	logic rst_s1_q, rst_s2_q;
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rst_s1_q <= 1'b0;
			rst_s2_q <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_s2_q <= rst_s1_q;
		end
	end
	// every other register resets from the released copy
	wire logic rst_ok = rst_s2_q;

	// status and io come from other logic or pins; two stages each
	msl_status_t               st_s1_q, st_q;
	msl_blk_t [NBLK-1:0]       blk_s1_q, blk_q;
	logic [$clog2(NBLK)-1:0]   sel_s1_q, sel_q;
	always_ff @(posedge mclk or negedge rst_ok) begin
		if (!rst_ok) begin
			st_s1_q  <= '0;
			st_q     <= '0;
			blk_s1_q <= '0;
			blk_q    <= '0;
			sel_s1_q <= '0;
			sel_q    <= '0;
		end else begin
			st_s1_q  <= status_in;
			st_q     <= st_s1_q;
			blk_s1_q <= blk_in;
			blk_q    <= blk_s1_q;
			sel_s1_q <= blk_sel;
			sel_q    <= sel_s1_q;
		end
	end

	////////////////////////////////////////////////////////////////////
	// common flash timebase

	localparam int CW = $clog2(HALF_CYC + 1);
	logic [CW-1:0] div_q, div_d;
	logic          blink_q, blink_d;
	always_comb begin
		div_d   = div_q + CW'(1);
		blink_d = blink_q;
		if (div_q == CW'(HALF_CYC - 1)) begin
			div_d   = '0;
			blink_d = ~blink_q;
		end
	end
	// one divider for every flashing indicator keeps them in phase
	always_ff @(posedge mclk or negedge rst_ok) begin
		if (!rst_ok) begin
			div_q   <= '0;
			blink_q <= 1'b0;
		end else begin
			div_q   <= div_d;
			blink_q <= blink_d;
		end
	end

	////////////////////////////////////////////////////////////////////
	// status indicators

	msl_leds_t leds_q, leds_d;
	logic      topo_q, topo_d;
	logic      link_ok;
	always_comb begin
		leds_d = '0;
		// standalone must be star; lower class in a ring never links
		topo_d  = (st_q.standalone && st_q.ring_topology)
			|| (st_q.ring_topology && !st_q.higher_class);
		link_ok = !topo_d;

		if (st_q.major_err)
			leds_d.run = 1'b0;
		else if (st_q.unit_test_busy || st_q.fw_update_busy
			|| st_q.addr_init_busy)
			leds_d.run = blink_q;
		else
			leds_d.run = st_q.normal_op;

		if (st_q.major_err || st_q.moderate_err)
			leds_d.err = 1'b1;
		else if (st_q.minor_err)
			leds_d.err = blink_q;

		leds_d.ctrl_exec = st_q.ctrl_exec;

		if (st_q.cfg_download)
			leds_d.config_state_indicator = blink_q;
		else
			leds_d.config_state_indicator = st_q.cfg_done_ok;

		leds_d.link_p1 = st_q.link_up_p1;
		leds_d.link_p2 = st_q.link_up_p2;

		if (st_q.standalone || st_q.own_disconnected || !link_ok)
			leds_d.cyclic_link_indicator = 1'b0;
		else if (st_q.cyclic == MSL_CYC_RUN)
			leds_d.cyclic_link_indicator = 1'b1;
		else if (st_q.cyclic == MSL_CYC_STOP)
			leds_d.cyclic_link_indicator = blink_q;

		leds_d.jack_p1 = 1'b0;
		leds_d.jack_p2 = 1'b0;
	end

	////////////////////////////////////////////////////////////////////
	// terminal block indicators

	logic [NBLK-1:0]  tno_q, tno_d;
	logic [IO_W-1:0]  in_q, in_d, out_q, out_d;
	logic             bi_q, bi_d, bo_q, bo_d;
	msl_blk_t         b;
	logic [IO_W-1:0]  outv;
	logic [IO_W-1:0]  lo_mask;
	logic             bov;
	always_comb begin
		b       = blk_q[sel_q];
		tno_d   = '0;
		in_d    = '0;
		out_d   = '0;
		bi_d    = 1'b0;
		bo_d    = 1'b0;
		lo_mask = {{(IO_W-DIFF_W){1'b0}}, {DIFF_W{1'b1}}};
		for (int i = 0; i < IO_W; i++) begin
			outv[i] = b.output_source_select[i] ? b.user_out[i]
				: b.remote_output_bit[i];
		end
		bov = b.bidir_output_source_select ? b.bidir_user_out
			: b.bidir_remote_out;
		case (b.kind)
			MSL_BLK_DC: begin
				tno_d[sel_q] = 1'b1;
				in_d  = b.in_pos;
				out_d = outv;
			end
			MSL_BLK_DIFF: begin
				tno_d[sel_q] = 1'b1;
				// inputs carry the positive leg only
				in_d  = b.in_pos & lo_mask;
				out_d = outv & lo_mask;
				if (b.bidir_output_value_direction)
					bo_d = bov;
				else
					bi_d = b.bidir_in_pos;
			end
			default: begin
				tno_d = '0;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////
	// output registers

	always_ff @(posedge mclk or negedge rst_ok) begin
		if (!rst_ok) begin
			leds_q <= '0;
			topo_q <= 1'b0;
		end else begin
			leds_q <= leds_d;
			topo_q <= topo_d;
		end
	end

	// io row is registered apart so it can be retimed alone
	always_ff @(posedge mclk or negedge rst_ok) begin
		if (!rst_ok) begin
			tno_q  <= '0;
			in_q   <= '0;
			out_q  <= '0;
			bi_q   <= 1'b0;
			bo_q   <= 1'b0;
		end else begin
			tno_q  <= tno_d;
			in_q   <= in_d;
			out_q  <= out_d;
			bi_q   <= bi_d;
			bo_q   <= bo_d;
		end
	end

	assign leds           = leds_q;
	assign topology_fault = topo_q;
	assign terminal_no    = tno_q;
	assign in_leds        = in_q;
	assign out_leds       = out_q;
	assign bidir_in_led   = bi_q;
	assign bidir_out_led  = bo_q;

endmodule

/* File: tb/msl_props.sv */
// port checks for the indicator driver
`timescale 1ns/1ns
module msl_props #(
	parameter int NBLK = 6
) (
	input wire logic                         mclk,
	input wire logic                         rst_n,
	input wire msl_pkg::msl_status_t         status_in,
	input wire logic [$clog2(NBLK)-1:0]      blk_sel,
	input wire msl_pkg::msl_blk_t [NBLK-1:0] blk_in,
	input wire msl_pkg::msl_leds_t           leds,
	input wire logic [NBLK-1:0]              terminal_no,
	input wire logic [15:0]                  in_leds,
	input wire logic [15:0]                  out_leds,
	input wire logic                         bidir_in_led,
	input wire logic                         bidir_out_led,
	input wire logic                         topology_fault
);
	import msl_pkg::*;
	// gate until the internal reset copy and the sync chain have flushed
	logic [3:0] up_q;
	logic [3:0] up_d;
	logic       ok;
	assign ok = up_q == 4'h8;
	always_comb up_d = ok ? up_q : up_q + 4'h1;
	always_ff @(posedge mclk or negedge rst_n)
		if (!rst_n) up_q <= 4'h0;
		else up_q <= up_d;
	default clocking @(posedge mclk);
	endclocking
	default disable iff (!rst_n);
	chk_jack_dark: assert property (!leds.jack_p1 && !leds.jack_p2)
		else $error("jack lit");
	chk_ctrl_follow: assert property (ok |->
		leds.ctrl_exec == $past(status_in.ctrl_exec, 3)) else $error("ctrl");
	chk_link_one: assert property (ok |->
		leds.link_p1 == $past(status_in.link_up_p1, 3)) else $error("p1");
	chk_err_lit: assert property (ok &&
		$past(status_in.major_err | status_in.moderate_err, 3) |-> leds.err)
		else $error("err");
	chk_run_dark: assert property (ok &&
		$past(status_in.major_err, 3) |-> !leds.run) else $error("run");
	chk_diff_upper: assert property (ok &&
		$past(blk_in[blk_sel].kind, 3) == MSL_BLK_DIFF
		|-> {in_leds[15:8], out_leds[15:8]} == 16'h0000) else $error("dif");
	chk_analog_blank: assert property (ok &&
		$past(blk_in[blk_sel].kind, 3) == MSL_BLK_ANALOG |-> terminal_no == 0
		&& in_leds == 0 && !bidir_in_led && !bidir_out_led) else $error("ana");
	chk_ring_class: assert property (ok &&
		$past(status_in.ring_topology && !status_in.higher_class, 3)
		|-> topology_fault && !leds.cyclic_link_indicator) else $error("rng");
endmodule
bind msl_driver msl_props #(.NBLK(NBLK)) u_msl_props (.mclk(mclk),
	.rst_n(rst_n), .status_in(status_in), .blk_sel(blk_sel),
	.blk_in(blk_in), .leds(leds), .terminal_no(terminal_no),
	.in_leds(in_leds), .out_leds(out_leds), .bidir_in_led(bidir_in_led),
	.bidir_out_led(bidir_out_led), .topology_fault(topology_fault));

/* File: tb/msl_panel.sv */
// indicator model that times the run indicator's blink
`timescale 1ns/1ns
module msl_panel (
	input wire logic mclk,
	input wire logic run,
	output int       gap
);
	logic prev = 0;
	int   cnt  = 0;
	always_ff @(posedge mclk) begin
		prev <= run;
		if (run != prev) begin
			gap <= cnt;
			cnt <= 1;
		end else cnt <= cnt + 1;
	end
endmodule

/* File: tb/tb.sv */
// random bench for the indicator driver against a reference model
`timescale 1ns/1ns
module tb;
	import msl_pkg::*;
	localparam int HC = 4;
	localparam int NB = 6;
	logic              mclk = 0;
	logic              rst_n = 0;
	msl_status_t       st = '0;
	logic [2:0]        sel = '0;
	msl_blk_t [NB-1:0] blk = '0;
	msl_leds_t         leds;
	logic [NB-1:0]     tno;
	logic [15:0]       inl, outl;
	logic [15:0]       r = 16'h0032;
	logic              bi, bo, tf;
	int                gap;
	int                mismatches = 0;
	int                num_checks = 0;
	always #4 mclk = ~mclk;
	msl_driver #(.HALF_CYC(HC), .NBLK(NB)) u_msl_driver (.mclk(mclk),
		.rst_n(rst_n), .status_in(st), .blk_sel(sel), .blk_in(blk),
		.leds(leds), .terminal_no(tno), .in_leds(inl), .out_leds(outl),
		.bidir_in_led(bi), .bidir_out_led(bo), .topology_fault(tf));
	msl_panel u_msl_panel (.mclk(mclk), .run(leds.run), .gap(gap));
	//////////////////////////////////////
	function automatic logic [15:0] nx(logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction
	task automatic check(string n, logic [15:0] e, logic [15:0] g);
		num_checks++;
		if (g !== e) begin
			mismatches++;
			$display("[FAIL] %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic tally_and_finish();
		if (mismatches == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// flashing fields are masked: the panel times only run's blink, and run's phase is checked against err at the end
	task automatic judge();
		msl_blk_t    b;
		msl_leds_t   e, m;
		logic [15:0] ei, eo;
		logic [NB-1:0] et;
		logic        f, g, ebi, ebo;
		b = blk[sel];
		f = st.ring_topology & (st.standalone | !st.higher_class);
		g = !(st.standalone | st.own_disconnected | f);
		e = '0;
		m = '0;
		e.run = !st.major_err & st.normal_op;
		m.run = !st.major_err & (st.unit_test_busy | st.fw_update_busy
			| st.addr_init_busy);
		e.err = st.major_err | st.moderate_err;
		m.err = !e.err & st.minor_err;
		e.ctrl_exec = st.ctrl_exec;
		e.config_state_indicator = st.cfg_done_ok;
		m.config_state_indicator = st.cfg_download;
		e.link_p1 = st.link_up_p1;
		e.link_p2 = st.link_up_p2;
		e.cyclic_link_indicator = g & (st.cyclic == MSL_CYC_RUN);
		m.cyclic_link_indicator = g & (st.cyclic == MSL_CYC_STOP);
		et = NB'(1) << sel;
		ei = b.in_pos;
		eo = b.output_source_select & b.user_out
			| ~b.output_source_select & b.remote_output_bit;
		ebi = 0;
		ebo = 0;
		if (b.kind == MSL_BLK_DIFF) begin
			ei[15:8] = 8'h00;
			eo[15:8] = 8'h00;
			ebi = !b.bidir_output_value_direction & b.bidir_in_pos;
			ebo = b.bidir_output_value_direction & (b.bidir_output_source_select
				? b.bidir_user_out : b.bidir_remote_out);
		end
		if (b.kind == MSL_BLK_ANALOG) {ei, eo, et} = '0;
		check("leds", 16'(e & ~m), 16'(leds & ~m));
		check("leds", 16'(e & ~m), 16'(leds & ~m));
		check("leds", 16'(e & ~m), 16'(leds & ~m));
		check("fault", 16'(f), 16'(tf));
		check("tno", 16'(et), 16'(tno));
		check("in", ei, inl);
		check("out", eo, outl);
		check("bidir", 16'({ebi, ebo}), 16'({bi, bo}));
	endtask
	initial begin
		repeat (4) @(negedge mclk);
		rst_n = 1;
		repeat (4) @(negedge mclk);
		for (int i = 0; i < 300; i++) begin
			for (int k = 0; k < NB * 5; k++) begin
				r = nx(r);
				blk[k/5] = msl_blk_t'({blk[k/5][54:0], r});
				blk[k/5].kind = msl_blk_kind_t'(2'(r % 3));
			end
			st = msl_status_t'({r, 2'h0});
			st.cyclic = msl_cyc_t'(2'(r % 3));
			sel = 3'(r % NB);
			repeat (3) @(negedge mclk);
			judge();
		end
		st = '0;
		st.unit_test_busy = 1;
		st.minor_err = 1;
		repeat (40) @(negedge mclk);
		check("gap", 16'(HC), 16'(gap));
		check("phase", 16'(leds.run), 16'(leds.err));
		tally_and_finish();
	end
	initial begin
		#(8 * 3000);
		mismatches++;
		tally_and_finish();
	end
endmodule
